// ==== core/sfpr_pkg.sv ====
/*
  Constants for the fraction and phase configuration register bank.
  Assumes 32-bit words arrive already assembled from the serial port.
*/
package sfpr_pkg;
  // ----------------------------------------------------------------
  // Select codes and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] SFPR_SEL_R0 = 4'h0;
  localparam logic [3:0] SFPR_SEL_R1 = 4'h1;
  localparam logic [3:0] SFPR_SEL_R2 = 4'h2;
  localparam logic [3:0] SFPR_SEL_R3 = 4'h3;
  localparam int SFPR_SEL_LSB    = 0;
  localparam int SFPR_INT_LSB    = 4;
  localparam int SFPR_INT_W      = 16;
  localparam int SFPR_PRESC_BIT  = 20;
  localparam int SFPR_ACAL_BIT   = 21;
  localparam int SFPR_MAIN_FRACTION_NUMERATOR_LSB  = 4;
  localparam int SFPR_MAIN_FRACTION_NUMERATOR_W    = 24;
  localparam int SFPR_AUX_FRACTION_MODULUS_LSB   = 4;
  localparam int SFPR_AUX_FRACTION_NUMERATOR_LSB  = 18;
  localparam int SFPR_AUX_W      = 14;
  localparam int SFPR_PHASE_LSB  = 4;
  localparam int SFPR_PHASE_W    = 24;
  localparam int SFPR_PADJ_BIT   = 28;
  localparam int SFPR_RSYNC_BIT  = 29;
  localparam int SFPR_SDRST_BIT  = 30;
  // ----------------------------------------------------------------
  // Integer divide limits per prescaler
  // ----------------------------------------------------------------
  localparam logic [15:0] SFPR_INT_MIN_P45 = 16'h0017;
  localparam logic [15:0] SFPR_INT_MAX_P45 = 16'h7FFF;
  localparam logic [15:0] SFPR_INT_MIN_P89 = 16'h004B;
  localparam logic [15:0] SFPR_INT_MAX_P89 = 16'hFFFF;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SFPR_RST_WORD = 32'h0000_0000;
endpackage

// ==== core/sfpr_regs.sv ====
/*
  Register bank for integer divide, main and auxiliary fractions and
  phase control of a fractional-N synthesizer.
  Assumes WORD_VALID is a one-cycle strobe on CLOCK with a complete word.
*/
`timescale 1ns/1ps
// Rules for this block and its host
// (R1) Integer field is 16 bits; 23..32767 accepted with four/five prescaler.
// (R2) Host keeps integer 75..65535 with eight/nine prescaler.
// (R3) Select code in bits 3:0; code 0001 stores register 1.
// (R4) Host writes zeros into register 1 bits 31:28.
// (R5) Register 1 bits 27:4 hold the 24-bit main fraction numerator.
// (R6) Host keeps main fraction below the main modulus.
// (R7) Buffered fields go active only on the next register 0 write.
// (R8) Code 0010 stores register 2.
// (R9) Register 2 bits 31:18 hold the auxiliary fraction numerator.
// (R10) Host keeps auxiliary numerator below auxiliary modulus.
// (R11) Register 2 bits 17:4 hold the 14-bit auxiliary modulus.
// (R12) Code 0011 stores register 3, phase control.
// (R13) Host writes zero into register 3 bit 31.
// (R14) Register 0 write resets modulator unless register 3 bit 30 set.
// (R15) Resync operates only while register 3 bit 29 is one.
// (R16) Resync takes effect only when auxiliary numerator is zero.
// (R17) Host keeps modulator reset enabled when using resync.
// (R18) Phase adjust bit 28 set makes each register 0 write shift phase.
// (R19) Host clears auto-calibration and sets reset-disable for phase adjust.
// (R20) Host never enables resync and phase adjust together.
// (R21) Each later register 0 write advances phase accumulator by phase value.
// (R22) Host selects divided feedback for phase-critical low-band use.
// (R23) Code 0000 stores register 0 and triggers buffered transfer.
// (R24) Register 0 bit 20 selects four/five or eight/nine prescaler.
// (R25) Register 0 bit 21 launches band calibration on register 0 write.
// (R26) Registers 1 to 3 keep contents until rewritten.
module sfpr_regs (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        WORD_VALID,
  input  wire logic [31:0] WORD_DATA,
  output logic      [15:0] INT_VALUE,
  output logic             PRESCALER_89,
  output logic             INT_IN_RANGE,
  output logic      [23:0] MAIN_FRACTION_NUMERATOR,
  output logic      [13:0] AUX_FRACTION_NUMERATOR,
  output logic      [13:0] AUX_FRACTION_MODULUS,
  output logic      [23:0] PHASE_VALUE,
  output logic      [23:0] PHASE_ACCUM,
  output logic             MODULATOR_RESET,
  output logic             BAND_CALIBRATION,
  output logic             PHASE_RESYNC_ARM,
  output logic             MODULATOR_RESET_DISABLE,
  output logic             PHASE_RESYNC_ENABLE,
  output logic             PHASE_ADJUST_ENABLE
);
  import sfpr_pkg::*;

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  logic [3:0]  sel;
  logic        wr0;
  logic        wr1;
  logic        wr2;
  logic        wr3;
  assign sel = WORD_DATA[SFPR_SEL_LSB +: 4];                         // (R3)
  assign wr0 = WORD_VALID && (sel == SFPR_SEL_R0);                   // (R23)
  assign wr1 = WORD_VALID && (sel == SFPR_SEL_R1);                   // (R3)
  assign wr2 = WORD_VALID && (sel == SFPR_SEL_R2);                   // (R8)
  assign wr3 = WORD_VALID && (sel == SFPR_SEL_R3);                   // (R12)

  // ----------------------------------------------------------------
  // Shadow stage
  // ----------------------------------------------------------------
  // Shadow words hold what the host wrote; the active outputs only move
  // on a register 0 write (except the register 3 phase control levels), so a multi-word retune lands at one edge.
  // Codes four to fifteen hit no entry and are dropped without a trace.
  logic [3:1]  wr_hit;
  logic [31:0] shadow_r   [1:3];
  logic [31:0] shadow_nxt [1:3];

  assign wr_hit = {wr3, wr2, wr1};

  for (genvar g = 1; g <= 3; g++) begin : g_shadow
    always_comb begin
      shadow_nxt[g] = wr_hit[g] ? WORD_DATA : shadow_r[g];           // (R26)
    end

    always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
        shadow_r[g] <= SFPR_RST_WORD;
      end else begin
        shadow_r[g] <= shadow_nxt[g];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shadow field taps
  // ----------------------------------------------------------------
  logic [23:0] sh_main_fraction_numerator;
  logic [13:0] sh_aux_fraction_numerator;
  logic [13:0] sh_aux_fraction_modulus;
  logic [23:0] sh_phase;
  logic        sh_padj;
  logic        sh_rsync;
  logic        sh_sdrst;

  assign sh_main_fraction_numerator = shadow_r[1][SFPR_MAIN_FRACTION_NUMERATOR_LSB +: SFPR_MAIN_FRACTION_NUMERATOR_W];     // (R5)
  assign sh_aux_fraction_numerator = shadow_r[2][SFPR_AUX_FRACTION_NUMERATOR_LSB +: SFPR_AUX_W];       // (R9)
  assign sh_aux_fraction_modulus  = shadow_r[2][SFPR_AUX_FRACTION_MODULUS_LSB +: SFPR_AUX_W];        // (R11)
  assign sh_phase = shadow_r[3][SFPR_PHASE_LSB +: SFPR_PHASE_W];     // (R21)
  assign sh_padj  = shadow_r[3][SFPR_PADJ_BIT];                      // (R18)
  assign sh_rsync = shadow_r[3][SFPR_RSYNC_BIT];                     // (R15)
  assign sh_sdrst = shadow_r[3][SFPR_SDRST_BIT];                     // (R14)

  // ----------------------------------------------------------------
  // Active datapath values
  // ----------------------------------------------------------------
  logic [15:0] int_new;
  logic        p89_new;
  logic [15:0] int_nxt;
  logic        p89_nxt;
  logic        rng_nxt;
  logic [23:0] main_fraction_numerator_nxt;
  logic [13:0] aux_fraction_numerator_nxt;
  logic [13:0] aux_fraction_modulus_nxt;
  logic [23:0] phv_nxt;
  logic [23:0] acc_nxt;

  assign int_new = WORD_DATA[SFPR_INT_LSB +: SFPR_INT_W];            // (R1)
  assign p89_new = WORD_DATA[SFPR_PRESC_BIT];                        // (R24)

  always_comb begin
    int_nxt   = INT_VALUE;
    p89_nxt   = PRESCALER_89;
    rng_nxt   = INT_IN_RANGE;
    main_fraction_numerator_nxt = MAIN_FRACTION_NUMERATOR;
    aux_fraction_numerator_nxt = AUX_FRACTION_NUMERATOR;
    aux_fraction_modulus_nxt  = AUX_FRACTION_MODULUS;
    phv_nxt   = PHASE_VALUE;
    acc_nxt   = PHASE_ACCUM;
    if (wr0) begin
      int_nxt   = int_new;                                           // (R23)
      p89_nxt   = p89_new;                                           // (R24)
      // The flag only reports an illegal value; the block still loads it,
      // so the host must watch the flag rather than count on a refusal.
      rng_nxt   = p89_new ? (int_new >= SFPR_INT_MIN_P89)             // (R24)
                          : (int_new >= SFPR_INT_MIN_P45 &&
                             int_new <= SFPR_INT_MAX_P45);            // (R1)
      main_fraction_numerator_nxt = sh_main_fraction_numerator;                                          // (R7)
      aux_fraction_numerator_nxt = sh_aux_fraction_numerator;                                          // (R7)
      aux_fraction_modulus_nxt  = sh_aux_fraction_modulus;                                           // (R7)
      phv_nxt   = sh_phase;                                          // (R7)
      if (sh_padj) begin
        // Wraps modulo one full turn, so the carry is dropped on purpose.
        acc_nxt = 24'(PHASE_ACCUM + sh_phase);                       // (R18) (R21)
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      INT_VALUE               <= SFPR_RST_WORD[15:0];
      PRESCALER_89            <= SFPR_RST_WORD[0];
      INT_IN_RANGE            <= SFPR_RST_WORD[0];
      MAIN_FRACTION_NUMERATOR <= SFPR_RST_WORD[23:0];
      AUX_FRACTION_NUMERATOR  <= SFPR_RST_WORD[13:0];
      AUX_FRACTION_MODULUS    <= SFPR_RST_WORD[13:0];
      PHASE_VALUE             <= SFPR_RST_WORD[23:0];
      PHASE_ACCUM             <= SFPR_RST_WORD[23:0];
    end else begin
      INT_VALUE               <= int_nxt;
      PRESCALER_89            <= p89_nxt;
      INT_IN_RANGE            <= rng_nxt;
      MAIN_FRACTION_NUMERATOR <= main_fraction_numerator_nxt;
      AUX_FRACTION_NUMERATOR  <= aux_fraction_numerator_nxt;
      AUX_FRACTION_MODULUS    <= aux_fraction_modulus_nxt;
      PHASE_VALUE             <= phv_nxt;
      PHASE_ACCUM             <= acc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register 0 pulses
  // ----------------------------------------------------------------
  // Each pulse stands for exactly one cycle after the register 0 write;
  // the analog side must latch it, since nothing here repeats it.
  logic mrst_nxt;
  logic acal_nxt;
  logic arm_nxt;

  always_comb begin
    mrst_nxt = 1'b0;
    acal_nxt = 1'b0;
    arm_nxt  = 1'b0;
    if (wr0) begin
      mrst_nxt = !sh_sdrst;                                          // (R14)
      acal_nxt = WORD_DATA[SFPR_ACAL_BIT];                           // (R25)
      arm_nxt  = sh_rsync && (sh_aux_fraction_numerator == 14'h0000);                 // (R15) (R16)
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      MODULATOR_RESET  <= SFPR_RST_WORD[0];
      BAND_CALIBRATION <= SFPR_RST_WORD[0];
      PHASE_RESYNC_ARM <= SFPR_RST_WORD[0];
    end else begin
      MODULATOR_RESET  <= mrst_nxt;
      BAND_CALIBRATION <= acal_nxt;
      PHASE_RESYNC_ARM <= arm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Phase control levels
  // ----------------------------------------------------------------
  // These follow a register 3 write directly, not the register 0 apply.
  logic dis_nxt;
  logic rsync_nxt;
  logic padj_nxt;

  always_comb begin
    dis_nxt   = shadow_nxt[3][SFPR_SDRST_BIT];                       // (R14)
    rsync_nxt = shadow_nxt[3][SFPR_RSYNC_BIT];                       // (R15)
    padj_nxt  = shadow_nxt[3][SFPR_PADJ_BIT];                        // (R18)
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      MODULATOR_RESET_DISABLE <= SFPR_RST_WORD[0];
      PHASE_RESYNC_ENABLE     <= SFPR_RST_WORD[0];
      PHASE_ADJUST_ENABLE     <= SFPR_RST_WORD[0];
    end else begin
      MODULATOR_RESET_DISABLE <= dis_nxt;
      PHASE_RESYNC_ENABLE     <= rsync_nxt;
      PHASE_ADJUST_ENABLE     <= padj_nxt;
    end
  end
endmodule

// ==== verif/sfpr_host.sv ====
/*
  Host model that writes whole 32-bit words into the register bank.
  Assumes one clock; the bench calls send from its scenarios.
*/
`timescale 1ns/1ps
module sfpr_host (
  input  wire logic        CLOCK,
  output logic             WORD_VALID,
  output logic      [31:0] WORD_DATA
);
  initial begin
    WORD_VALID = 1'b0;
    WORD_DATA  = 32'h0000_0000;
  end
  // The idle bus shows the inverted word so stale data is never mistaken for new.
  task automatic send(input logic [31:0] w);
    if (w[3:0] == 4'h1) w[31:28] = 4'h0;
    if (w[3:0] == 4'h3) w[31] = 1'b0;
    @(posedge CLOCK);
    WORD_VALID <= 1'b1;
    WORD_DATA  <= w;
    @(posedge CLOCK);
    WORD_VALID <= 1'b0;
    WORD_DATA  <= ~w;
  endtask
endmodule

// ==== verif/sfpr_regs_checker.sv ====
/*
  Assertion checker for the register bank.
  Assumes it is bound to sfpr_regs and sees only its ports.
*/
`timescale 1ns/1ps
module sfpr_regs_checker (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        WORD_VALID,
  input wire logic [31:0] WORD_DATA,
  input wire logic [15:0] INT_VALUE,
  input wire logic        PRESCALER_89,
  input wire logic        INT_IN_RANGE,
  input wire logic [23:0] MAIN_FRACTION_NUMERATOR,
  input wire logic [13:0] AUX_FRACTION_NUMERATOR,
  input wire logic [13:0] AUX_FRACTION_MODULUS,
  input wire logic [23:0] PHASE_VALUE,
  input wire logic [23:0] PHASE_ACCUM,
  input wire logic        MODULATOR_RESET,
  input wire logic        BAND_CALIBRATION,
  input wire logic        PHASE_RESYNC_ARM,
  input wire logic        MODULATOR_RESET_DISABLE,
  input wire logic        PHASE_RESYNC_ENABLE,
  input wire logic        PHASE_ADJUST_ENABLE
);
  import sfpr_pkg::*;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  wire logic [15:0] iv  = WORD_DATA[SFPR_INT_LSB +: SFPR_INT_W];
  wire logic        p89 = WORD_DATA[SFPR_PRESC_BIT];
  wire logic        w0  = WORD_VALID && (WORD_DATA[3:0] == SFPR_SEL_R0);
  wire logic        w3  = WORD_VALID && (WORD_DATA[3:0] == SFPR_SEL_R3);
  wire logic        ok  = p89 ? (iv >= SFPR_INT_MIN_P89)
                              : (iv >= SFPR_INT_MIN_P45 && iv <= SFPR_INT_MAX_P45);

  property p_mrst;
    1'b1 |=> MODULATOR_RESET == $past(w0 && !MODULATOR_RESET_DISABLE);
  endproperty
  a_mrst: assert property (p_mrst) else $error("modulator reset mismatch");
  property p_cal;
    1'b1 |=> BAND_CALIBRATION == $past(w0 && WORD_DATA[SFPR_ACAL_BIT]);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration pulse mismatch");
  property p_int;
    w0 |=> INT_VALUE == $past(iv) && PRESCALER_89 == $past(p89);
  endproperty
  a_int: assert property (p_int) else $error("integer load mismatch");
  property p_rng;
    w0 |=> INT_IN_RANGE == $past(ok);
  endproperty
  a_rng: assert property (p_rng) else $error("integer range flag mismatch");
  property p_buf;
    !w0 |=> $stable({MAIN_FRACTION_NUMERATOR, AUX_FRACTION_NUMERATOR,
                     AUX_FRACTION_MODULUS, PHASE_VALUE, INT_VALUE, PHASE_ACCUM});
  endproperty
  a_buf: assert property (p_buf) else $error("active value changed without apply");
  property p_lvl;
    w3 |=> {MODULATOR_RESET_DISABLE, PHASE_RESYNC_ENABLE, PHASE_ADJUST_ENABLE} ==
           $past(WORD_DATA[SFPR_SDRST_BIT:SFPR_PADJ_BIT]);
  endproperty
  a_lvl: assert property (p_lvl) else $error("phase control levels mismatch");
  property p_arm;
    1'b1 |=> PHASE_RESYNC_ARM == ($past(w0 && PHASE_RESYNC_ENABLE) &&
                                  AUX_FRACTION_NUMERATOR == 14'h0000);
  endproperty
  a_arm: assert property (p_arm) else $error("resync arm mismatch");
  property p_acc;
    w0 && PHASE_ADJUST_ENABLE |=> PHASE_ACCUM == 24'($past(PHASE_ACCUM) + PHASE_VALUE);
  endproperty
  a_acc: assert property (p_acc) else $error("phase step mismatch");
endmodule

bind sfpr_regs sfpr_regs_checker sfpr_regs_checker_i (
  .CLOCK                   (CLOCK),
  .RST                     (RST),
  .WORD_VALID              (WORD_VALID),
  .WORD_DATA               (WORD_DATA),
  .INT_VALUE               (INT_VALUE),
  .PRESCALER_89            (PRESCALER_89),
  .INT_IN_RANGE            (INT_IN_RANGE),
  .MAIN_FRACTION_NUMERATOR (MAIN_FRACTION_NUMERATOR),
  .AUX_FRACTION_NUMERATOR  (AUX_FRACTION_NUMERATOR),
  .AUX_FRACTION_MODULUS    (AUX_FRACTION_MODULUS),
  .PHASE_VALUE             (PHASE_VALUE),
  .PHASE_ACCUM             (PHASE_ACCUM),
  .MODULATOR_RESET         (MODULATOR_RESET),
  .BAND_CALIBRATION        (BAND_CALIBRATION),
  .PHASE_RESYNC_ARM        (PHASE_RESYNC_ARM),
  .MODULATOR_RESET_DISABLE (MODULATOR_RESET_DISABLE),
  .PHASE_RESYNC_ENABLE     (PHASE_RESYNC_ENABLE),
  .PHASE_ADJUST_ENABLE     (PHASE_ADJUST_ENABLE)
);

// ==== verif/sfpr_regs_tb.sv ====
/*
  Self-checking bench for the register bank.
  Assumes the host model drives every word; one clock at 100 MHz.
*/
`timescale 1ns/1ps
module sfpr_regs_tb;
  import sfpr_pkg::*;
  logic        CLOCK;
  logic        RST;
  logic        WORD_VALID;
  logic [31:0] WORD_DATA;
  logic [15:0] INT_VALUE;
  logic        PRESCALER_89;
  logic        INT_IN_RANGE;
  logic [23:0] MAIN_FRACTION_NUMERATOR;
  logic [13:0] AUX_FRACTION_NUMERATOR;
  logic [13:0] AUX_FRACTION_MODULUS;
  logic [23:0] PHASE_VALUE;
  logic [23:0] PHASE_ACCUM;
  logic        MODULATOR_RESET;
  logic        BAND_CALIBRATION;
  logic        PHASE_RESYNC_ARM;
  logic        MODULATOR_RESET_DISABLE;
  logic        PHASE_RESYNC_ENABLE;
  logic        PHASE_ADJUST_ENABLE;
  int          err_count = 0;
  int          cmp_count = 0;

  sfpr_regs sfpr_regs_i (
    .CLOCK                   (CLOCK),
    .RST                     (RST),
    .WORD_VALID              (WORD_VALID),
    .WORD_DATA               (WORD_DATA),
    .INT_VALUE               (INT_VALUE),
    .PRESCALER_89            (PRESCALER_89),
    .INT_IN_RANGE            (INT_IN_RANGE),
    .MAIN_FRACTION_NUMERATOR (MAIN_FRACTION_NUMERATOR),
    .AUX_FRACTION_NUMERATOR  (AUX_FRACTION_NUMERATOR),
    .AUX_FRACTION_MODULUS    (AUX_FRACTION_MODULUS),
    .PHASE_VALUE             (PHASE_VALUE),
    .PHASE_ACCUM             (PHASE_ACCUM),
    .MODULATOR_RESET         (MODULATOR_RESET),
    .BAND_CALIBRATION        (BAND_CALIBRATION),
    .PHASE_RESYNC_ARM        (PHASE_RESYNC_ARM),
    .MODULATOR_RESET_DISABLE (MODULATOR_RESET_DISABLE),
    .PHASE_RESYNC_ENABLE     (PHASE_RESYNC_ENABLE),
    .PHASE_ADJUST_ENABLE     (PHASE_ADJUST_ENABLE)
  );
  sfpr_host sfpr_host_i (.CLOCK(CLOCK), .WORD_VALID(WORD_VALID), .WORD_DATA(WORD_DATA));
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] r0(input logic [15:0] iv, input logic p, input logic c);
    return {10'h000, c, p, iv, SFPR_SEL_R0};
  endfunction
  task automatic wr(input logic [31:0] w);
    sfpr_host_i.send(w);
    #1;
  endtask
  task automatic t_buffer();
    wr(32'hFABC_DEF1);
    wr(32'h000C_01F2);
    wr(32'h0123_4563);
    wr(32'hFFFF_FFF4);
    chk({MAIN_FRACTION_NUMERATOR, AUX_FRACTION_NUMERATOR, AUX_FRACTION_MODULUS}, 64'h0);
    wr(r0(16'h0100, 1'b0, 1'b0));
    chk(MAIN_FRACTION_NUMERATOR, 24'hABCDEF);
    chk({AUX_FRACTION_NUMERATOR, AUX_FRACTION_MODULUS}, {14'h0003, 14'h001F});
    chk({PHASE_VALUE, INT_VALUE}, {24'h123456, 16'h0100});
    $display("test buffer done");
  endtask
  task automatic t_range();
    logic [16:0] cs [7] = '{17'h00016, 17'h00017, 17'h07FFF, 17'h08000,
                            17'h1004A, 17'h1004B, 17'h1FFFF};
    logic [6:0]  ok     = 7'b1100110;
    for (int i = 0; i < 7; i++) begin
      wr(r0(cs[i][15:0], cs[i][16], 1'b0));
      chk({PRESCALER_89, INT_IN_RANGE}, {cs[i][16], ok[i]});
    end
    $display("test range done");
  endtask
  task automatic t_phase();
    wr(32'h5100_0003);
    chk({MODULATOR_RESET_DISABLE, PHASE_RESYNC_ENABLE, PHASE_ADJUST_ENABLE}, 3'b101);
    wr(r0(16'h0100, 1'b0, 1'b0));
    chk({MODULATOR_RESET, BAND_CALIBRATION}, 2'b00);
    wr(r0(16'h0100, 1'b0, 1'b0));
    chk(PHASE_ACCUM, 24'h200000);
    wr(32'h0000_0003);
    chk({MODULATOR_RESET_DISABLE, PHASE_RESYNC_ENABLE, PHASE_ADJUST_ENABLE}, 3'b000);
    wr(r0(16'h0100, 1'b0, 1'b1));
    chk({MODULATOR_RESET, BAND_CALIBRATION, PHASE_ACCUM}, {2'b11, 24'h200000});
    $display("test phase done");
  endtask
  task automatic t_resync();
    wr(32'h2000_0003);
    chk({MODULATOR_RESET_DISABLE, PHASE_RESYNC_ENABLE, PHASE_ADJUST_ENABLE}, 3'b010);
    wr(32'h0004_01F2);
    wr(r0(16'h0100, 1'b0, 1'b0));
    chk(PHASE_RESYNC_ARM, 1'b0);
    wr(32'h0000_01F2);
    wr(r0(16'h0100, 1'b0, 1'b0));
    chk(PHASE_RESYNC_ARM, 1'b1);
    wr(32'h0000_0003);
    wr(r0(16'h0100, 1'b0, 1'b0));
    chk(PHASE_RESYNC_ARM, 1'b0);
    $display("test resync done");
  endtask
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    RST = 1'b1;
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    #1;
    chk({INT_VALUE, PHASE_ACCUM, MAIN_FRACTION_NUMERATOR}, 64'h0);
    t_buffer();
    t_range();
    t_phase();
    t_resync();
    final_report();
  end
  initial begin
    repeat (2000) @(posedge CLOCK);
    err_count++;
    final_report();
  end
endmodule
